/* File: pxs_sensor_regs.sv */
// Sensing control, result and threshold registers with conversion
// sequencing, ambient subtraction and persistent threshold interrupt.
// Assumes an external serial slave engine presents byte accesses, decodes
// command register I and reports when its transfer ends.
`timescale 1ns/1ps
`default_nettype none
`include "pxs_defines.svh"

module pxs_sensor_regs #(
	parameter int LED_HALF_CYC = `PXS_LED_HALF_CYC
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Byte register port from the serial slave engine
	input  wire logic [2:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	// Command register I fields and transfer end
	input  wire logic [2:0]  op_mode_i,
	input  wire logic [1:0]  persist_i,
	input  wire logic        cmd1_xfer_done_i,
	// Analog front end
	input  wire logic        osc_tick_i,
	input  wire logic [15:0] adc_count_i,
	input  wire logic [15:0] ambient_count_i,
	output logic             integrating_o,
	output logic      [1:0]  full_scale_range_o,
	output logic      [1:0]  led_current_o,
	output logic             led_drive_pin_o,
	// Interrupt flag and open-drain pin
	output logic             int_flag_o,
	output logic             int_pin_o,
	output logic             int_pin_oe_n_o
);
	import pxs_pkg::*;

	if (LED_HALF_CYC < 1) begin : g_chk
		$error("pxs_sensor_regs: LED_HALF_CYC must be positive");
	end

	// Reset release through two flops
	logic rst_s1_r;
	logic rst_s2_r;
	logic rst_n;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	assign rst_n = rst_s2_r;

	// Software-visible registers
	logic [7:0]  ctrl_r;
	logic [7:0]  ctrl_nxt;
	logic [15:0] lt_r;
	logic [15:0] lt_nxt;
	logic [15:0] ht_r;
	logic [15:0] ht_nxt;
	logic [7:0]  rdata_r;
	logic [7:0]  rdata_nxt;

	// Register writes; reset values of the thresholds form an open window
	always_comb begin
		ctrl_nxt = ctrl_r;
		lt_nxt   = lt_r;
		ht_nxt   = ht_r;
		if (reg_wr_i) begin
			case (reg_addr_i)
				`PXS_ADDR_CTRL:  ctrl_nxt       = reg_wdata_i;
				`PXS_ADDR_LT_LO: lt_nxt[7:0]    = reg_wdata_i;
				`PXS_ADDR_LT_HI: lt_nxt[15:8]   = reg_wdata_i;
				`PXS_ADDR_HT_LO: ht_nxt[7:0]    = reg_wdata_i;
				`PXS_ADDR_HT_HI: ht_nxt[15:8]   = reg_wdata_i;
				default:         ctrl_nxt       = ctrl_r;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= `PXS_CTRL_RST;
			lt_r   <= {`PXS_LT_RST, `PXS_LT_RST};
			ht_r   <= {`PXS_HT_RST, `PXS_HT_RST};
		end else begin
			ctrl_r <= ctrl_nxt;
			lt_r   <= lt_nxt;
			ht_r   <= ht_nxt;
		end
	end

	// Conversion sequencer state
	pxs_state_t  state_r;
	pxs_state_t  state_nxt;
	logic [7:0]  cfg_r;
	logic [7:0]  cfg_nxt;
	logic [2:0]  mode_prev_r;
	logic        once_done_r;
	logic        once_done_nxt;
	logic [15:0] result_r;
	logic [15:0] result_nxt;
	logic        conv_done_r;
	logic        conv_done_nxt;
	logic        start;
	logic        abort;
	logic        tmr_busy;
	logic        tmr_done;
	logic        mode_chg;
	logic        run_mode;
	logic        once_mode;
	logic        prox_mode;
	logic [15:0] conv_val;

	assign mode_chg  = (op_mode_i != mode_prev_r);
	assign run_mode  = op_mode_i[1];
	assign once_mode = ~op_mode_i[2];
	assign prox_mode = op_mode_i[0];

	// Conversion value: raw count, or signed proximity less ambient
	always_comb begin
		logic signed [16:0] diff;
		logic signed [16:0] lim_hi;
		logic signed [16:0] lim_lo;
		logic [4:0]         nbits;
		diff   = $signed({1'b0, adc_count_i}) - $signed({1'b0, ambient_count_i});
		nbits  = pxs_res_width(cfg_r[`PXS_CTRL_RES_HI:`PXS_CTRL_RES_LO]);
		lim_hi = $signed(17'((17'h00001 << (nbits - 5'd1)) - 17'h00001));
		lim_lo = -lim_hi - 17'sh00001;
		if (prox_mode && cfg_r[`PXS_CTRL_SCHEME]) begin
			if (diff > lim_hi) begin
				diff = lim_hi;
			end else if (diff < lim_lo) begin
				diff = lim_lo;
			end
			conv_val = diff[15:0];
		end else begin
			conv_val = adc_count_i;
		end
		conv_val = conv_val & pxs_res_mask(cfg_r[`PXS_CTRL_RES_HI:`PXS_CTRL_RES_LO]);
	end

	// Sequencer: settings latch at start, result at timer completion
	always_comb begin
		state_nxt     = state_r;
		cfg_nxt       = cfg_r;
		once_done_nxt = once_done_r;
		result_nxt    = result_r;
		conv_done_nxt = 1'b0;
		start         = 1'b0;
		abort         = 1'b0;
		if (mode_chg || cmd1_xfer_done_i) begin
			once_done_nxt = 1'b0;
		end
		case (state_r)
			PXS_IDLE: begin
				if (run_mode && !mode_chg && !once_done_r) begin
					start     = 1'b1;
					cfg_nxt   = ctrl_r;
					state_nxt = PXS_INTEG;
				end
			end
			PXS_INTEG: begin
				if (mode_chg || !run_mode) begin
					abort     = 1'b1;
					state_nxt = PXS_IDLE;
				end else if (tmr_done) begin
					result_nxt    = conv_val;
					conv_done_nxt = 1'b1;
					state_nxt     = PXS_DONE;
				end
			end
			PXS_DONE: begin
				if (run_mode && !once_mode && !mode_chg) begin
					start     = 1'b1;
					cfg_nxt   = ctrl_r;
					state_nxt = PXS_INTEG;
				end else begin
					once_done_nxt = run_mode & once_mode & ~mode_chg;
					state_nxt     = PXS_IDLE;
				end
			end
			default: state_nxt = PXS_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= PXS_IDLE;
			cfg_r       <= `PXS_CTRL_RST;
			mode_prev_r <= 3'h0;
			once_done_r <= 1'b0;
			result_r    <= `PXS_RES_RST;
			conv_done_r <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			cfg_r       <= cfg_nxt;
			mode_prev_r <= op_mode_i;
			once_done_r <= once_done_nxt;
			result_r    <= result_nxt;
			conv_done_r <= conv_done_nxt;
		end
	end

	pxs_integ_timer #(
		.CNT_W(`PXS_INTEG_BITS)
	) u_timer (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n),
		.start_i   (start),
		.abort_i   (abort),
		.res_code_i(cfg_nxt[`PXS_CTRL_RES_HI:`PXS_CTRL_RES_LO]),
		.osc_tick_i(osc_tick_i),
		.busy_o    (tmr_busy),
		.done_o    (tmr_done)
	);

	// Persistence count and sticky flag
	logic [4:0] pers_r;
	logic [4:0] pers_nxt;
	logic       flag_r;
	logic       flag_nxt;
	logic [4:0] pers_m;
	logic       out_win;

	// Unsigned 16-bit window test on each new result
	assign out_win = (result_r < lt_r) || (result_r > ht_r);

	always_comb begin
		case (persist_i)
			2'b00:   pers_m = 5'd1;
			2'b01:   pers_m = 5'd4;
			2'b10:   pers_m = 5'd8;
			default: pers_m = 5'd16;
		endcase
		pers_nxt = pers_r;
		flag_nxt = flag_r;
		if (cmd1_xfer_done_i) begin
			flag_nxt = 1'b0;
		end
		if (mode_chg) begin
			pers_nxt = 5'd0;
		end else if (conv_done_r) begin
			if (out_win) begin
				// Saturate so a long excursion cannot wrap the count
				if (pers_r < pers_m) begin
					pers_nxt = pers_r + 5'd1;
				end
				if (pers_r + 5'd1 >= pers_m) begin
					flag_nxt = 1'b1;
				end
			end else begin
				pers_nxt = 5'd0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pers_r <= 5'd0;
			flag_r <= 1'b0;
		end else begin
			pers_r <= pers_nxt;
			flag_r <= flag_nxt;
		end
	end

	// Registered read data; command I lives outside, reads as zero here
	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd_i) begin
			case (reg_addr_i)
				`PXS_ADDR_CTRL:   rdata_nxt = ctrl_r;
				`PXS_ADDR_RES_LO: rdata_nxt = result_r[7:0];
				`PXS_ADDR_RES_HI: rdata_nxt = result_r[15:8];
				`PXS_ADDR_LT_LO:  rdata_nxt = lt_r[7:0];
				`PXS_ADDR_LT_HI:  rdata_nxt = lt_r[15:8];
				`PXS_ADDR_HT_LO:  rdata_nxt = ht_r[7:0];
				`PXS_ADDR_HT_HI:  rdata_nxt = ht_r[15:8];
				default:          rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// LED only during proximity integrations, settings from the latch
	pxs_led_mod #(
		.HALF_CYC(LED_HALF_CYC)
	) u_led (
		.clk_i  (clk_i),
		.rst_n_i(rst_n),
		.en_i   (tmr_busy & prox_mode),
		.mod_i  (cfg_r[`PXS_CTRL_FREQ]),
		.led_o  (led_drive_pin_o)
	);

	// Outputs
	assign reg_rdata_o        = rdata_r;
	assign integrating_o      = tmr_busy;
	assign full_scale_range_o = cfg_r[`PXS_CTRL_RNG_HI:`PXS_CTRL_RNG_LO];
	assign led_current_o      = cfg_r[`PXS_CTRL_CUR_HI:`PXS_CTRL_CUR_LO];
	assign int_flag_o         = flag_r;
	assign int_pin_o          = 1'b0;
	assign int_pin_oe_n_o     = ~flag_r;

endmodule : pxs_sensor_regs
`default_nettype wire

/* File: pxs_defines.svh */
// Constants of the proximity sensor configuration, result and threshold
// logic. Assumes inclusion by every design file of the block.
// Operation
// - Scheme bit set: proximity minus ambient, signed, n-1 magnitude bits.
// - Control bit 6 picks LED drive: zero steady, one modulated 360 kHz.
// - Control bits 5:4 pick LED current 12.5, 25, 50 or 100 mA.
// - Control bits 3:2 pick 16, 12, 8 or 4 bits resolution.
// - Each integration lasts two to the n oscillator cycles.
// - Control bits 1:0 pick one of four full-scale ranges, 00 lowest.
// - Result low byte reads at 02, high byte at 03, read only.
// - Result right aligned from bit 0, unused upper bits zero.
// - Both result bytes update at the end of every conversion.
// - Registers 04 and 05 hold lower threshold, reset 00.
// - Registers 06 and 07 hold upper threshold, reset FF.
// - Modulated LED runs at 360 kHz with equal on and off times.
// - Flag and pin set after m consecutive out-of-window results.
// - Flag and pin stay set until a command I transfer ends.
// - Persistence counter returns to zero on any mode change.
`ifndef PXS_DEFINES_SVH
`define PXS_DEFINES_SVH

// Register offsets
`define PXS_ADDR_CTRL      3'h1
`define PXS_ADDR_RES_LO    3'h2
`define PXS_ADDR_RES_HI    3'h3
`define PXS_ADDR_LT_LO     3'h4
`define PXS_ADDR_LT_HI     3'h5
`define PXS_ADDR_HT_LO     3'h6
`define PXS_ADDR_HT_HI     3'h7

// Reset values
`define PXS_CTRL_RST       8'h00
`define PXS_RES_RST        16'h0000
`define PXS_LT_RST         8'h00
`define PXS_HT_RST         8'hFF

// Control field positions
`define PXS_CTRL_SCHEME    7
`define PXS_CTRL_FREQ      6
`define PXS_CTRL_CUR_HI    5
`define PXS_CTRL_CUR_LO    4
`define PXS_CTRL_RES_HI    3
`define PXS_CTRL_RES_LO    2
`define PXS_CTRL_RNG_HI    1
`define PXS_CTRL_RNG_LO    0

// Timing: system clock and LED modulation
`define PXS_CLK_PERIOD_NS  4
`define PXS_MOD_FREQ_KHZ   360
`define PXS_LED_HALF_CYC   ((1000000 / (2 * `PXS_MOD_FREQ_KHZ)) / `PXS_CLK_PERIOD_NS)

// Widest integration count, in oscillator cycles (2^16)
`define PXS_INTEG_BITS     16

`endif

/* File: pxs_pkg.sv */
// Types and decode helpers of the proximity sensor register block.
// Assumes pxs_defines.svh is on the include path.
`include "pxs_defines.svh"

package pxs_pkg;

	// Conversion sequencer states, Gray along idle-integrate-done
	typedef enum logic [1:0] {
		PXS_IDLE  = 2'b00,
		PXS_INTEG = 2'b01,
		PXS_DONE  = 2'b11
	} pxs_state_t;

	typedef logic [1:0] pxs_code_t;

	// Resolution code to bit count: 00-16, 01-12, 10-8, 11-4
	function automatic logic [4:0] pxs_res_width(input pxs_code_t code);
		case (code)
			2'b00:   pxs_res_width = 5'd16;
			2'b01:   pxs_res_width = 5'd12;
			2'b10:   pxs_res_width = 5'd8;
			default: pxs_res_width = 5'd4;
		endcase
	endfunction : pxs_res_width

	// Mask of the n valid low bits for a resolution code
	function automatic logic [15:0] pxs_res_mask(input pxs_code_t code);
		case (code)
			2'b00:   pxs_res_mask = 16'hFFFF;
			2'b01:   pxs_res_mask = 16'h0FFF;
			2'b10:   pxs_res_mask = 16'h00FF;
			default: pxs_res_mask = 16'h000F;
		endcase
	endfunction : pxs_res_mask

endpackage : pxs_pkg

/* File: pxs_led_mod.sv */
// LED drive gate: steady or square wave with equal on and off halves.
// Assumes en_i low outside proximity integrations.
`timescale 1ns/1ps
`default_nettype none
`include "pxs_defines.svh"

module pxs_led_mod #(
	parameter int HALF_CYC = `PXS_LED_HALF_CYC
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Control
	input  wire logic en_i,
	input  wire logic mod_i,
	// LED drive
	output logic      led_o
);
	import pxs_pkg::*;

	if (HALF_CYC < 1 || HALF_CYC > 1023) begin : g_chk
		$error("pxs_led_mod: HALF_CYC out of range");
	end

	localparam logic [9:0] HALF_LAST = 10'(HALF_CYC - 1);

	logic [9:0] cnt_r;
	logic [9:0] cnt_nxt;
	logic       phase_r;
	logic       phase_nxt;
	logic       led_r;
	logic       led_nxt;

	// Half period counter; idles at its wrap point so the turn-on edge
	// acts as a toggle and the first on-half is as long as the others
	always_comb begin
		cnt_nxt   = cnt_r;
		phase_nxt = phase_r;
		if (!en_i) begin
			cnt_nxt   = HALF_LAST;
			phase_nxt = 1'b0;
		end else if (cnt_r == HALF_LAST) begin
			cnt_nxt   = 10'h000;
			phase_nxt = ~phase_r;
		end else begin
			cnt_nxt = cnt_r + 10'h001;
		end
		led_nxt = en_i & (mod_i ? phase_nxt : 1'b1);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r   <= HALF_LAST;
			phase_r <= 1'b0;
			led_r   <= 1'b0;
		end else begin
			cnt_r   <= cnt_nxt;
			phase_r <= phase_nxt;
			led_r   <= led_nxt;
		end
	end

	assign led_o = led_r;

endmodule : pxs_led_mod
`default_nettype wire

/* File: pxs_integ_timer.sv */
// Integration timer: counts 2^n oscillator ticks, then pulses done.
// Assumes osc_tick_i is a one-cycle pulse per oscillator period.
`timescale 1ns/1ps
`default_nettype none
`include "pxs_defines.svh"

module pxs_integ_timer #(
	parameter int CNT_W = `PXS_INTEG_BITS
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	// Control
	input  wire logic              start_i,
	input  wire logic              abort_i,
	input  wire pxs_pkg::pxs_code_t res_code_i,
	input  wire logic              osc_tick_i,
	// Status
	output logic                   busy_o,
	output logic                   done_o
);
	import pxs_pkg::*;

	if (CNT_W != 16) begin : g_chk
		$error("pxs_integ_timer: CNT_W must be 16");
	end

	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic        busy_r;
	logic        busy_nxt;
	logic        done_r;
	logic        done_nxt;
	logic [15:0] last;

	// Last tick index 2^n - 1 equals the resolution mask
	always_comb begin
		last     = pxs_res_mask(res_code_i);
		cnt_nxt  = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		if (abort_i) begin
			busy_nxt = 1'b0;
			cnt_nxt  = 16'h0000;
		end else if (start_i) begin
			busy_nxt = 1'b1;
			cnt_nxt  = 16'h0000;
		end else if (busy_r && osc_tick_i) begin
			if (cnt_r == last) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r  <= 16'h0000;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign busy_o = busy_r;
	assign done_o = done_r;

endmodule : pxs_integ_timer
`default_nettype wire

/* File: pxs_sensor_regs_props.sv */
// Checker of interrupt pin, read port, settings and LED timing.
// Assumes a bind onto pxs_sensor_regs, seeing only its ports.
`timescale 1ns/1ps
`default_nettype none

module pxs_regs_chk #(
	parameter int LED_HALF_CYC = 347
) (
	// Clock, reset and register port
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic [2:0] reg_addr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       cmd1_xfer_done_i,
	// Status and pins
	input wire logic       integrating_o,
	input wire logic [1:0] full_scale_range_o,
	input wire logic [1:0] led_current_o,
	input wire logic       led_drive_pin_o,
	input wire logic       int_flag_o,
	input wire logic       int_pin_o,
	input wire logic       int_pin_oe_n_o
);
	logic [9:0] run_r;
	logic       led_r;
	logic       in_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// Cycles the LED level has held; saturates so DC stays quiet
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_r <= 10'h000;
			led_r <= 1'b0;
			in_r  <= 1'b0;
		end else if (led_drive_pin_o != led_r) begin
			run_r <= 10'h001;
			led_r <= led_drive_pin_o;
			in_r  <= integrating_o;
		end else if (run_r != 10'h3FF) begin
			run_r <= run_r + 10'h001;
		end
	end

	// Pin pulls low exactly while the flag stands
	pin_follows_flag_a: assert property (int_pin_oe_n_o == !int_flag_o
		&& int_pin_o == 1'b0) else $error("pin enable not tied to flag");
	// Flag rises two edges after the integration ends
	flag_rise_a: assert property ($rose(int_flag_o) |->
		$past(integrating_o, 3) && !$past(integrating_o, 2))
		else $error("flag rose without a finished conversion");
	flag_hold_a: assert property (int_flag_o && !cmd1_xfer_done_i
		&& !$past(cmd1_xfer_done_i) |=> int_flag_o)
		else $error("flag dropped without a transfer");
	// A new result in the clearing cycle wins, so that cycle is exempt
	flag_clear_a: assert property (cmd1_xfer_done_i &&
		($past(integrating_o) || !$past(integrating_o, 2)) |->
		##[1:2] !int_flag_o) else $error("flag not cleared");
	// Read data holds between reads; address 0 reads zero
	rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without a read");
	unmapped_read_a: assert property (reg_rd_i &&
		reg_addr_i == 3'h0 |=> reg_rdata_o == 8'h00)
		else $error("address 0 read not zero");
	// Modulated halves are equal; LED dark outside integration
	led_half_a: assert property ($changed(led_drive_pin_o) && in_r
		&& integrating_o |-> run_r == LED_HALF_CYC)
		else $error("LED half period wrong");
	led_idle_a: assert property (!integrating_o &&
		!$past(integrating_o) |-> !led_drive_pin_o)
		else $error("LED on outside integration");
	settings_held_a: assert property (integrating_o &&
		$past(integrating_o) && $past(integrating_o, 2) |->
		$stable(full_scale_range_o) && $stable(led_current_o))
		else $error("settings moved during integration");

	flag_cov: cover property ($rose(int_flag_o));
	led_cov: cover property ($changed(led_drive_pin_o) && in_r);
	unmapped_cov: cover property (reg_rd_i && reg_addr_i == 3'h0);
endmodule : pxs_regs_chk

bind pxs_sensor_regs pxs_regs_chk #(.LED_HALF_CYC(LED_HALF_CYC)) u_chk (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.cmd1_xfer_done_i(cmd1_xfer_done_i), .integrating_o(integrating_o),
	.full_scale_range_o(full_scale_range_o), .led_current_o(led_current_o),
	.led_drive_pin_o(led_drive_pin_o), .int_flag_o(int_flag_o),
	.int_pin_o(int_pin_o), .int_pin_oe_n_o(int_pin_oe_n_o)
);
`default_nettype wire

/* File: pxs_host_model.sv */
// Host model: byte register accesses and command I transfers.
// Assumes the bench calls its tasks; it drives at falling edges.
`timescale 1ns/1ps
`default_nettype none

module pxs_host_model (
	// Clock
	input  wire logic       clk_i,
	// Register port
	output logic      [2:0] reg_addr_o,
	output logic            reg_wr_o,
	output logic      [7:0] reg_wdata_o,
	output logic            reg_rd_o,
	input  wire logic [7:0] reg_rdata_i,
	// Command I fields
	output logic      [2:0] op_mode_o,
	output logic      [1:0] persist_o,
	output logic            cmd1_xfer_done_o
);
	// Idle port at time zero
	initial begin
		reg_addr_o = 3'h0;
		reg_wr_o = 1'b0;
		reg_wdata_o = 8'h00;
		reg_rd_o = 1'b0;
		op_mode_o = 3'h0;
		persist_o = 2'h0;
		cmd1_xfer_done_o = 1'b0;
	end

	// Released lines show inverted values, never the last ones
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge clk_i);
		reg_wr_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask : wr

	// Data is registered, so it is taken one cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(negedge clk_i);
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(negedge clk_i);
		reg_rd_o = 1'b0;
		d = reg_rdata_i;
		reg_addr_o = ~a;
	endtask : rd

	// Command I write: new fields plus end-of-transfer pulse
	task automatic cmd1(input logic [2:0] md, input logic [1:0] p);
		@(negedge clk_i);
		op_mode_o = md;
		persist_o = p;
		cmd1_xfer_done_o = 1'b1;
		@(negedge clk_i);
		cmd1_xfer_done_o = 1'b0;
	endtask : cmd1
endmodule : pxs_host_model
`default_nettype wire

/* File: pxs_sensor_regs_tb.sv */
// Self-checking bench of the sensor register block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pxs_defines.svh"

module pxs_sensor_regs_tb;
	localparam int HALF  = 3;
	localparam int LIMIT = 95000;

	logic        clk, rst_n, wr, rd, xfer, integ, led, flag, pin, pin_oe_n;
	logic [2:0]  addr, mode;
	logic [1:0]  persist, rng, cur;
	logic        tick = 1'b1;
	logic        slow = 1'b0;
	logic [7:0]  wdata, rdata, rv;
	logic [15:0] adc, amb, ex;
	int          bad_count, n_compared, len, lon, n, m;
	int          cyc = 0;

	pxs_host_model u_host (.clk_i(clk), .reg_addr_o(addr), .reg_wr_o(wr),
		.reg_wdata_o(wdata), .reg_rd_o(rd), .reg_rdata_i(rdata),
		.op_mode_o(mode), .persist_o(persist), .cmd1_xfer_done_o(xfer));

	pxs_sensor_regs #(.LED_HALF_CYC(HALF)) dut (.clk_i(clk),
		.rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr),
		.reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.op_mode_i(mode), .persist_i(persist), .cmd1_xfer_done_i(xfer),
		.osc_tick_i(tick), .adc_count_i(adc), .ambient_count_i(amb),
		.integrating_o(integ), .full_scale_range_o(rng),
		.led_current_o(cur), .led_drive_pin_o(led), .int_flag_o(flag),
		.int_pin_o(pin), .int_pin_oe_n_o(pin_oe_n));

	initial clk = 1'b0;
	always #2 clk = ~clk;

	// Oscillator tick every cycle, or every other one when slow
	always @(negedge clk) tick <= !slow || !tick;

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			bad_count++;
			$display("[FAIL] cycle limit exp %0d got %0d", LIMIT, cyc);
			stop_test();
		end
	end

	task automatic chk(input string s, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask : chk

	task automatic chk_rng(input string s, input int lo, input int hi,
		input int g);
		n_compared++;
		if (g < lo || g > hi) begin
			bad_count++;
			$display("[FAIL] %s exp %0d..%0d got %0d", s, lo, hi, g);
		end
	endtask : chk_rng

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
		u_host.rd(a, rv);
		chk($sformatf("reg %0d", a), e, rv);
	endtask : rd_chk

	// Waits for k conversion ends, bounded, then lets flag settle
	task automatic ends(input int k);
		int w;
		repeat (k) begin
			w = 0;
			while (integ !== 1'b1 && w < 10) begin
				@(negedge clk);
				w++;
			end
			while (integ === 1'b1 && w < 70000) begin
				@(negedge clk);
				w++;
			end
		end
		repeat (2) @(negedge clk);
	endtask : ends

	// One conversion, counting integration and LED-on cycles
	task automatic convert(input logic [2:0] md);
		int w;
		w = 0;
		len = 0;
		lon = 0;
		u_host.cmd1(md, 2'h0);
		while (integ !== 1'b1 && w < 10) begin
			@(negedge clk);
			w++;
		end
		while (integ === 1'b1 && len < 70000) begin
			@(negedge clk);
			len++;
			lon += (led === 1'b1);
		end
		repeat (2) @(negedge clk);
	endtask : convert

	task automatic stop_test();
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test

	initial begin
		rst_n = 1'b0;
		adc = 16'h0000;
		amb = 16'h0000;
		bad_count = 0;
		n_compared = 0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		// Reset values, address 0 included
		for (int a = 0; a < 8; a++) begin
			rd_chk(3'(a), (a >= 6) ? 8'hFF : 8'h00);
		end
		// Result bytes ignore writes; threshold bytes are kept apart
		u_host.wr(`PXS_ADDR_RES_LO, 8'h5A);
		u_host.wr(`PXS_ADDR_RES_HI, 8'hA5);
		rd_chk(`PXS_ADDR_RES_LO, 8'h00);
		rd_chk(`PXS_ADDR_RES_HI, 8'h00);
		for (int a = 4; a < 8; a++) u_host.wr(3'(a), 8'h30 + 8'(a));
		for (int a = 4; a < 8; a++) begin
			rd_chk(3'(a), 8'h30 + 8'(a));
		end
		// Lower bound 0100 splits across bytes; upper FFFF
		u_host.wr(`PXS_ADDR_LT_LO, 8'h00);
		u_host.wr(`PXS_ADDR_LT_HI, 8'h01);
		u_host.wr(`PXS_ADDR_HT_LO, 8'hFF);
		u_host.wr(`PXS_ADDR_HT_HI, 8'hFF);
		// Every resolution: 2^n cycles, result masked to n bits
		for (int r = 3; r >= 0; r--) begin
			n = 16 - 4 * r;
			adc = 16'hA5C3 + 16'(r);
			ex = adc & 16'((1 << n) - 1);
			u_host.wr(`PXS_ADDR_CTRL, {4'h8, 2'(r), 2'h0});
			convert(3'b010);
			chk_rng("integration", 2 ** n, 2 ** n + 3, len);
			chk_rng("IR LED", 0, 0, lon);
			rd_chk(`PXS_ADDR_RES_LO, ex[7:0]);
			rd_chk(`PXS_ADDR_RES_HI, ex[15:8]);
		end
		// Signed proximity, current, range and LED drive per code
		for (int k = 0; k < 4; k++) begin
			adc = k[0] ? 16'h0002 : 16'h0005;
			amb = k[0] ? 16'h0005 : 16'h0002;
			u_host.wr(`PXS_ADDR_CTRL, {1'b1, k[0], 2'(k), 2'h3, 2'(k)});
			convert(3'b011);
			chk("range", 8'(k), {6'h00, rng});
			chk("current", 8'(k), {6'h00, cur});
			rd_chk(`PXS_ADDR_RES_LO, k[0] ? 8'h0D : 8'h03);
			rd_chk(`PXS_ADDR_RES_HI, 8'h00);
			if (k[0]) chk_rng("mod LED", len / 2 - 3, len / 2 + 3, lon);
			else chk_rng("DC LED", len - 2, len, lon);
		end
		// Half-rate oscillator: 16 ticks must take about 32 cycles
		u_host.wr(`PXS_ADDR_CTRL, 8'h8C);
		slow = 1'b1;
		convert(3'b010);
		chk_rng("slow integration", 31, 33, len);
		slow = 1'b0;
		// Each persistence count; the transfer of the stop command clears the flag
		u_host.wr(`PXS_ADDR_CTRL, 8'h88);
		adc = 16'h00FF;
		for (int p = 0; p < 4; p++) begin
			m = (p == 0) ? 1 : 4 << (p - 1);
			u_host.cmd1(3'b110, 2'(p));
			ends(m - 1);
			chk("flag early", 8'h00, {7'h00, flag});
			ends(1);
			chk("flag set", 8'h01, {7'h00, flag});
			chk("pin enable", 8'h00, {7'h00, pin_oe_n});
			ends(1);
			chk("flag held", 8'h01, {7'h00, flag});
			u_host.cmd1(3'b000, 2'(p));
			repeat (3) @(negedge clk);
			chk("flag clear", 8'h00, {7'h00, flag});
		end
		stop_test();
	end
endmodule : pxs_sensor_regs_tb
`default_nettype wire
